// ### hw/power_mode_cfg.svh
// Constants for the power mode controller: offsets, reset values, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef POWER_MODE_CFG_SVH
`define POWER_MODE_CFG_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define PMC_PCTRL_IDX 10'h087
`define PMC_STATUS_IDX 10'h088
`define PMC_ADDR_W 12

// ==========================================================
// Reset values
`define PMC_PCTRL_RESET 8'h00
`define PMC_PCTRL_RSVD_MASK 8'hDF
`define PMC_RESET_VECTOR 16'h0000

// ==========================================================
// Timing
`define PMC_CLK_PERIOD_NS 8
`define PMC_MACHINE_CYCLE_CLKS 12
`define PMC_RST_HOLD_MCYC 2
`define PMC_RST_HOLD_CLKS (`PMC_RST_HOLD_MCYC * `PMC_MACHINE_CYCLE_CLKS)
`define PMC_SETTLE_CLKS_LONG 32768
`define PMC_SETTLE_CLKS_SHORT 2048
`define PMC_PD_RESET_HOLD_MS 10
`define PMC_PD_REENTRY_US 4

// ==========================================================
// Synchronised pin vector layout
`define PMC_PIN_W 9
`define PMC_PIN_RST 8
`define PMC_PIN_RESET_LVL 9'h0FF

`endif

// ### hw/power_mode_pkg.sv
// Types shared by the power mode controller modules.
// Assumes power_mode_cfg.svh is on the include path.
`include "power_mode_cfg.svh"

package power_mode_pkg;

  // ==========================================================
  // Power control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic baud_double;
    logic frame_error_select;
    logic reserved;
    logic power_on_flag;
    logic general_flag_one;
    logic general_flag_zero;
    logic power_down_request;
    logic idle_request;
  } power_ctrl_t;

  // ==========================================================
  // Operating modes
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_IDLE,
    MODE_PDOWN,
    MODE_SETTLE
  } mode_t;

  // Avalon-MM request as seen by the slave
  typedef struct packed {
    logic [`PMC_ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avs_req_t;

endpackage : power_mode_pkg

// ### hw/pin_sync.sv
// Three-stage synchroniser for a vector of asynchronous pins.
// Assumes pins are slow against core_clk_i; glitches shorter than two cycles are lost.
`timescale 1ns/1ps
`include "power_mode_cfg.svh"

module pin_sync #(
  parameter int WIDTH = `PMC_PIN_W,
  parameter logic [WIDTH-1:0] RESET_LVL = '0
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  // ==========================================================
  // Per pin: stage 1 feeds only stage 2; a change counts when 2 and 3 agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_pin
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic lvl_ff;
      always_ff @(posedge core_clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          s1_ff <= RESET_LVL[g];
          s2_ff <= RESET_LVL[g];
          s3_ff <= RESET_LVL[g];
          lvl_ff <= RESET_LVL[g];
        end
        else
        begin
          s1_ff <= pin_i[g];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff)
          begin
            lvl_ff <= s3_ff;
          end
        end
      end
      assign level_o[g] = lvl_ff;
    end
  endgenerate

endmodule : pin_sync

// ### hw/settle_counter.sv
// Clock settling counter started on a pin wake from power-down.
// Assumes start_i is a one-cycle pulse on core_clk_i; abort_i is a level that stays high while the core reset lasts.
`timescale 1ns/1ps

module settle_counter #(
  parameter int SETTLE_CLKS = 32768
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic abort_i,
  output logic busy_o,
  output logic done_o
);

  localparam int CW = $clog2(SETTLE_CLKS + 1);
  localparam logic [CW-1:0] LAST = CW'(SETTLE_CLKS - 1);

  logic [CW-1:0] cnt_ff;
  logic busy_ff;
  logic done_ff;

  // ==========================================================
  // Count full SETTLE_CLKS cycles, then one done pulse
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      if (abort_i)
      begin
        busy_ff <= 1'b0;
        cnt_ff <= '0;
      end
      else if (start_i)
      begin
        busy_ff <= 1'b1;
        cnt_ff <= '0;
      end
      else if (busy_ff)
      begin
        if (cnt_ff == LAST)
        begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
        else
        begin
          cnt_ff <= cnt_ff + CW'(1);
        end
      end
    end
  end

  assign busy_o = busy_ff;
  assign done_o = done_ff;

endmodule : settle_counter

// ### hw/power_mode_controller.sv
// Power mode controller: power control register, idle and power-down sequencing.
// Assumes a CPU core, interrupt controller and serial port on core_clk_i around it.
//
// Summary of operation
// - Eight-bit power control register with baud, frame, flag and mode request bits.
// - Baud doubling bit doubles serial rate in modes one to three only.
// - Frame error select turns serial control bit seven into the frame error flag.
// - Power-on flag set by power-on, cleared only by a software write.
// - Two general flags are plain storage with no hardware effect.
// - Idle gates only the CPU clock; peripherals keep their clock.
// - CPU state is frozen intact while idle.
// - Idle holds port pins, drives address latch and program store strobes high.
// - An enabled interrupt clears idle request and resumes the CPU.
// - Reset pin held two machine cycles gives a full internal reset.
// - Power-down stops oscillator and flash, keeps RAM and register contents.
// - In power-down only wake detection on interrupt, receive, counter and reset pins stays active.
// - Wake from power-down by reset, interrupt pins, receive or counter pins.
// - Reset wake restarts execution at the reset vector.
// - Falling interrupt edge exits power-down, restarts oscillator, starts settle count.
// - CPU clock stays blocked until the settle counter reaches full count.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "power_mode_cfg.svh"

module power_mode_controller #(
  parameter int SETTLE_CLKS = `PMC_SETTLE_CLKS_LONG
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic power_on_resetn_i,
  input wire logic [`PMC_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic reset_pin_i,
  input wire logic [3:0] ext_irq_n_i,
  input wire logic rxd_i,
  input wire logic [2:0] counter_input_i,
  input wire logic irq_pending_i,
  input wire logic [1:0] serial_mode_i,
  input wire logic cpu_ale_i,
  input wire logic cpu_program_store_strobe_i,
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic osc_run_o,
  output logic flash_en_o,
  output logic port_hold_o,
  output logic ale_o,
  output logic program_store_strobe_o,
  output logic core_reset_o,
  output logic [15:0] reset_vector_o,
  output logic baud_double_o,
  output logic frame_error_select_o
);

  localparam int RST_HOLD = `PMC_RST_HOLD_CLKS;
  localparam logic [4:0] RST_HOLD_C = 5'(RST_HOLD);

  power_mode_pkg::avs_req_t req;
  power_mode_pkg::power_ctrl_t pctrl;
  power_mode_pkg::mode_t mode_ff;
  power_mode_pkg::mode_t nxt_mode;

  logic [`PMC_PIN_W-1:0] pin_raw;
  logic [`PMC_PIN_W-1:0] pin_lvl;
  logic [`PMC_PIN_W-1:0] pin_prev_ff;
  logic [9:0] reg_idx;
  logic [31:0] rdata_ff;
  logic [7:0] wr_byte;
  logic [4:0] rst_cnt_ff;
  logic bus_req, wait_ff, pctrl_wr;
  logic baud_double_ff, frame_error_select_ff, power_on_flag_ff, gf_one_ff, gf_zero_ff;
  logic pd_req_ff, idle_req_ff, core_reset_ff;
  logic pin_wake, irq_fall, settle_start, settle_busy, settle_done, wake_clear;

  // ==========================================================
  // Pin synchronisers and edge detection
  assign pin_raw = {reset_pin_i, counter_input_i, rxd_i, ext_irq_n_i};

  pin_sync #(
    .WIDTH(`PMC_PIN_W),
    .RESET_LVL(`PMC_PIN_RESET_LVL)
  ) u_pin_sync (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .pin_i(pin_raw),
    .level_o(pin_lvl)
  );

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pin_prev_ff <= `PMC_PIN_RESET_LVL;
    end
    else
    begin
      pin_prev_ff <= pin_lvl;
    end
  end

  // Interrupt pins wake on a falling edge, receive and counter pins on any edge
  assign irq_fall = |(pin_prev_ff[3:0] & ~pin_lvl[3:0]);
  assign pin_wake = irq_fall | (|(pin_prev_ff[7:4] ^ pin_lvl[7:4]));

  // ==========================================================
  // Reset pin qualification: two machine cycles of high level
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_cnt_ff <= 5'h00;
      core_reset_ff <= 1'b0;
    end
    else
    begin
      if (!pin_lvl[`PMC_PIN_RST])
      begin
        rst_cnt_ff <= 5'h00;
      end
      else if (rst_cnt_ff != RST_HOLD_C)
      begin
        rst_cnt_ff <= rst_cnt_ff + 5'h01;
      end
      core_reset_ff <= pin_lvl[`PMC_PIN_RST] && (rst_cnt_ff == RST_HOLD_C);
    end
  end

  // ==========================================================
  // Avalon-MM slave: one wait cycle, then answer
  assign req = {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i,
                avs_byteenable_i};

  assign reg_idx = req.address[`PMC_ADDR_W-1:2];
  assign bus_req = req.read | req.write;
  assign wr_byte = req.writedata[7:0];
  // Write lands at the edge where waitrequest is sampled low
  assign pctrl_wr = req.write && !wait_ff && req.byteenable[0]
                    && !core_reset_ff && (reg_idx == `PMC_PCTRL_IDX);

  assign pctrl = {baud_double_ff, frame_error_select_ff, 1'b0, power_on_flag_ff,
                  gf_one_ff, gf_zero_ff, pd_req_ff, idle_req_ff};

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      if (bus_req && wait_ff)
      begin
        wait_ff <= 1'b0;
        case (reg_idx)
          `PMC_PCTRL_IDX: rdata_ff <= {24'h00_0000, pctrl};
          `PMC_STATUS_IDX: rdata_ff <= {28'h000_0000, settle_busy, core_reset_ff, mode_ff};
          default: rdata_ff <= 32'h0000_0000;
        endcase
      end
      else
      begin
        wait_ff <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Power control register fields cleared by internal reset
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      baud_double_ff <= 1'b0;
      frame_error_select_ff <= 1'b0;
      gf_one_ff <= 1'b0;
      gf_zero_ff <= 1'b0;
    end
    else if (core_reset_ff)
    begin
      baud_double_ff <= 1'b0;
      frame_error_select_ff <= 1'b0;
      gf_one_ff <= 1'b0;
      gf_zero_ff <= 1'b0;
    end
    else if (pctrl_wr)
    begin
      baud_double_ff <= wr_byte[7];
      frame_error_select_ff <= wr_byte[6];
      gf_one_ff <= wr_byte[3];
      gf_zero_ff <= wr_byte[2];
    end
  end

  // Only power-on sets it; a write of zero clears, a write of one keeps it
  always_ff @(posedge core_clk_i or negedge power_on_resetn_i)
  begin
    if (!power_on_resetn_i)
    begin
      power_on_flag_ff <= 1'b1;
    end
    else if (pctrl_wr && !wr_byte[4])
    begin
      power_on_flag_ff <= 1'b0;
    end
  end

  // Mode requests: set by software, cleared by hardware on wake
  assign wake_clear = (mode_ff == power_mode_pkg::MODE_IDLE && irq_pending_i)
                      || settle_done || core_reset_ff;

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pd_req_ff <= 1'b0;
      idle_req_ff <= 1'b0;
    end
    else if (wake_clear)
    begin
      pd_req_ff <= 1'b0;
      idle_req_ff <= 1'b0;
    end
    else if (pctrl_wr)
    begin
      pd_req_ff <= wr_byte[1];
      idle_req_ff <= wr_byte[0];
    end
  end

  // ==========================================================
  // Mode sequencing
  always_comb
  begin
    nxt_mode = mode_ff;
    case (mode_ff)
      power_mode_pkg::MODE_RUN:
      begin
        if (pctrl_wr && wr_byte[1])
        begin
          nxt_mode = power_mode_pkg::MODE_PDOWN;
        end
        else if (pctrl_wr && wr_byte[0])
        begin
          nxt_mode = power_mode_pkg::MODE_IDLE;
        end
      end
      power_mode_pkg::MODE_IDLE:
      begin
        if (core_reset_ff || irq_pending_i)
        begin
          nxt_mode = power_mode_pkg::MODE_RUN;
        end
      end
      power_mode_pkg::MODE_PDOWN:
      begin
        if (core_reset_ff)
        begin
          nxt_mode = power_mode_pkg::MODE_RUN;
        end
        else if (pin_wake)
        begin
          nxt_mode = power_mode_pkg::MODE_SETTLE;
        end
      end
      power_mode_pkg::MODE_SETTLE:
      begin
        if (core_reset_ff || settle_done)
        begin
          nxt_mode = power_mode_pkg::MODE_RUN;
        end
      end
      default:
      begin
        nxt_mode = power_mode_pkg::MODE_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mode_ff <= power_mode_pkg::MODE_RUN;
    end
    else
    begin
      mode_ff <= nxt_mode;
    end
  end

  assign settle_start = (mode_ff == power_mode_pkg::MODE_PDOWN) && !core_reset_ff && pin_wake;

  settle_counter #(
    .SETTLE_CLKS(SETTLE_CLKS)
  ) u_settle (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .start_i(settle_start),
    .abort_i(core_reset_ff),
    .busy_o(settle_busy),
    .done_o(settle_done)
  );

  // ==========================================================
  // Clock, strobe and serial outputs, all registered
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cpu_clk_en_o <= 1'b1;
      periph_clk_en_o <= 1'b1;
      osc_run_o <= 1'b1;
      flash_en_o <= 1'b1;
      port_hold_o <= 1'b0;
      ale_o <= 1'b1;
      program_store_strobe_o <= 1'b1;
    end
    else
    begin
      // A gated CPU clock is what keeps every CPU register intact
      cpu_clk_en_o <= (nxt_mode == power_mode_pkg::MODE_RUN);
      periph_clk_en_o <= (nxt_mode == power_mode_pkg::MODE_RUN)
                         || (nxt_mode == power_mode_pkg::MODE_IDLE);
      osc_run_o <= (nxt_mode != power_mode_pkg::MODE_PDOWN);
      // Flash stays off until the clock is trusted again
      flash_en_o <= (nxt_mode == power_mode_pkg::MODE_RUN)
                    || (nxt_mode == power_mode_pkg::MODE_IDLE);
      port_hold_o <= (nxt_mode != power_mode_pkg::MODE_RUN);
      ale_o <= (nxt_mode == power_mode_pkg::MODE_IDLE) ? 1'b1 : cpu_ale_i;
      program_store_strobe_o <= (nxt_mode == power_mode_pkg::MODE_IDLE) ? 1'b1
                                : cpu_program_store_strobe_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      core_reset_o <= 1'b0;
      reset_vector_o <= `PMC_RESET_VECTOR;
      baud_double_o <= 1'b0;
      frame_error_select_o <= 1'b0;
    end
    else
    begin
      core_reset_o <= core_reset_ff;
      reset_vector_o <= `PMC_RESET_VECTOR;
      // Mode 0 is the fixed-rate shift mode and ignores doubling
      baud_double_o <= baud_double_ff && (serial_mode_i != 2'h0);
      frame_error_select_o <= frame_error_select_ff;
    end
  end

  assign avs_readdata_o = rdata_ff;
  assign avs_waitrequest_o = wait_ff;

endmodule : power_mode_controller

// ### verif/wake_partner.sv
// Far-side model: wake pins and reset pin driven around the controller.
// Assumes the bench calls its tasks; idle levels are pulled high, reset low.
`timescale 1ns/1ps

module wake_partner (
  input wire logic core_clk_i,
  input wire logic cpu_clk_en_i,
  output logic [3:0] ext_irq_n_o,
  output logic rxd_o,
  output logic [2:0] counter_input_o,
  output logic reset_pin_o
);
  // ==========================================================
  // Pin levels
  initial
  begin
    ext_irq_n_o = 4'hF;
    rxd_o = 1'b1;
    counter_input_o = 3'h7;
    reset_pin_o = 1'b0;
  end

  // Pull wake source k low and hold it until the CPU runs again
  task automatic wake(input int k, output int n);
    n = 0;
    @(posedge core_clk_i);
    if (k < 4)
      ext_irq_n_o[k] <= 1'b0;
    else if (k == 4)
      rxd_o <= 1'b0;
    else
      counter_input_o[k-5] <= 1'b0;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while (cpu_clk_en_i !== 1'b1);
    ext_irq_n_o <= 4'hF;
    rxd_o <= 1'b1;
    counter_input_o <= 3'h7;
  endtask : wake

  // Long hold covers the pin synchroniser as well as two machine cycles
  task automatic hold_reset(input int cyc);
    @(posedge core_clk_i);
    reset_pin_o <= 1'b1;
    repeat (cyc) @(posedge core_clk_i);
    reset_pin_o <= 1'b0;
  endtask : hold_reset
endmodule : wake_partner

// ### verif/power_mode_controller_props.sv
// Port checker for the power mode controller.
// Assumes SETTLE_CLKS of 16; the settle window below is written for it.
`timescale 1ns/1ps

module power_mode_controller_props #(
  parameter int SETTLE_CLKS = 16
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic irq_pending_i,
  input wire logic [1:0] serial_mode_i,
  input wire logic cpu_ale_i,
  input wire logic cpu_clk_en_o,
  input wire logic periph_clk_en_o,
  input wire logic osc_run_o,
  input wire logic flash_en_o,
  input wire logic port_hold_o,
  input wire logic ale_o,
  input wire logic program_store_strobe_o,
  input wire logic core_reset_o,
  input wire logic [15:0] reset_vector_o,
  input wire logic baud_double_o
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer one cycle after request");
  a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_idle_strobes: assert property (periph_clk_en_o && !cpu_clk_en_o |->
    ale_o && program_store_strobe_o && port_hold_o && flash_en_o && osc_run_o)
    else $error("idle outputs wrong");
  a_pd_stopped: assert property (!osc_run_o |->
    !cpu_clk_en_o && !periph_clk_en_o && !flash_en_o && port_hold_o)
    else $error("power-down outputs wrong");
  a_run_follow: assert property ($past(resetn_i) && cpu_clk_en_o && $past(cpu_clk_en_o) |->
    ale_o == $past(cpu_ale_i)) else $error("strobe not passed in run");
  a_baud_mode: assert property (baud_double_o |-> $past(serial_mode_i) != 2'b00)
    else $error("baud doubled in mode zero");
  a_irq_wake: assert property (periph_clk_en_o && !cpu_clk_en_o && irq_pending_i |->
    ##[1:2] cpu_clk_en_o) else $error("interrupt did not end idle");
  // Blocked for the first 15 cycles of the 16-cycle count, running within four more; a short count would let the CPU run on a bad clock
  // A reset pin ends power-down or settling at once, so it is not a short count
  a_settle_hold: assert property (disable iff (!resetn_i || core_reset_o)
    $rose(osc_run_o) |-> !cpu_clk_en_o [*8] ##1
    !cpu_clk_en_o [*7] ##[1:4] cpu_clk_en_o) else $error("settle window wrong");
  a_reset_run: assert property (core_reset_o && $past(core_reset_o) |->
    cpu_clk_en_o && !port_hold_o) else $error("core reset not in run");
  a_vector_zero: assert property (reset_vector_o == 16'h0000)
    else $error("reset vector not zero");
endmodule : power_mode_controller_props

bind power_mode_controller power_mode_controller_props #(.SETTLE_CLKS(SETTLE_CLKS)) u_props (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .irq_pending_i(irq_pending_i), .serial_mode_i(serial_mode_i), .cpu_ale_i(cpu_ale_i),
  .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o), .osc_run_o(osc_run_o),
  .flash_en_o(flash_en_o), .port_hold_o(port_hold_o), .ale_o(ale_o),
  .program_store_strobe_o(program_store_strobe_o), .core_reset_o(core_reset_o),
  .reset_vector_o(reset_vector_o), .baud_double_o(baud_double_o));

// ### verif/power_mode_controller_tb.sv
// Self-checking bench for the power mode controller.
// Assumes the wake partner model and the bound checker are compiled with it.
`timescale 1ns/1ps
`include "power_mode_cfg.svh"

module power_mode_controller_tb;
  localparam int SETTLE = 16;
  localparam logic [11:0] PC = {`PMC_PCTRL_IDX, 2'b00};
  localparam logic [11:0] ST = {`PMC_STATUS_IDX, 2'b00};
  logic core_clk_i, resetn_i, power_on_resetn_i, avs_read_i, avs_write_i, irq_pending_i;
  logic cpu_ale_i, prog_strobe_in, avs_waitrequest_o, rxd_i, reset_pin_i;
  logic [11:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [3:0] avs_byteenable_i, ext_irq_n_i;
  logic [2:0] counter_input_i;
  logic [1:0] serial_mode_i;
  logic cpu_clk_en_o, periph_clk_en_o, osc_run_o, flash_en_o, port_hold_o, ale_o;
  logic program_store_strobe_o, core_reset_o, baud_double_o, frame_error_select_o;
  logic [15:0] reset_vector_o;
  int errors, checks, cycles, n;

  power_mode_controller #(.SETTLE_CLKS(SETTLE)) DUT (.core_clk_i(core_clk_i),
    .resetn_i(resetn_i), .power_on_resetn_i(power_on_resetn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .reset_pin_i(reset_pin_i), .ext_irq_n_i(ext_irq_n_i), .rxd_i(rxd_i),
    .counter_input_i(counter_input_i), .irq_pending_i(irq_pending_i),
    .serial_mode_i(serial_mode_i), .cpu_ale_i(cpu_ale_i), .cpu_program_store_strobe_i(prog_strobe_in),
    .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o), .osc_run_o(osc_run_o),
    .flash_en_o(flash_en_o), .port_hold_o(port_hold_o), .ale_o(ale_o),
    .program_store_strobe_o(program_store_strobe_o), .core_reset_o(core_reset_o),
    .reset_vector_o(reset_vector_o), .baud_double_o(baud_double_o),
    .frame_error_select_o(frame_error_select_o));
  wake_partner P (.core_clk_i, .cpu_clk_en_i(cpu_clk_en_o), .ext_irq_n_o(ext_irq_n_i),
    .rxd_o(rxd_i), .counter_input_o(counter_input_i), .reset_pin_o(reset_pin_i));

  // ==========================================================
  // Clock and hang limit
  initial
  begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      final_report();
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // No cycle count assumed: only the hang limit ends a wait
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d,
    input logic [3:0] be);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= {24'h00_0000, d};
    avs_byteenable_i <= be;
    do
      @(posedge core_clk_i);
    while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(q, exp, what);
  endtask : rd

  task automatic final_report();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  // ==========================================================
  // Sequence
  initial
  begin
    errors = 0;
    checks = 0;
    cycles = 0;
    resetn_i = 1'b0;
    power_on_resetn_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 12'h000;
    avs_writedata_i = 32'h0000_0000;
    avs_byteenable_i = 4'hF;
    irq_pending_i = 1'b0;
    serial_mode_i = 2'h0;
    cpu_ale_i = 1'b0;
    prog_strobe_in = 1'b0;
    repeat (8) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    power_on_resetn_i <= 1'b1;
    rd(PC, 32'h0000_0010, "flag after power-on");
    rd(ST, 32'h0000_0000, "status run");
    bus(1'b1, PC, 8'h1D, 4'hF);
    repeat (2) @(posedge core_clk_i);
    chk({cpu_clk_en_o, periph_clk_en_o, ale_o, program_store_strobe_o, port_hold_o},
      32'h0000_000F, "idle outputs");
    rd(ST, 32'h0000_0001, "status idle");
    irq_pending_i <= 1'b1;
    do
      @(posedge core_clk_i);
    while (cpu_clk_en_o !== 1'b1);
    irq_pending_i <= 1'b0;
    rd(PC, 32'h0000_001C, "idle bit cleared");
    bus(1'b1, PC, 8'h1D, 4'hF);
    P.hold_reset(40);
    chk(core_reset_o, 32'h0000_0001, "core reset while pin held");
    repeat (4) @(posedge core_clk_i);
    chk(cpu_clk_en_o, 32'h0000_0001, "run after reset pin");
    rd(PC, 32'h0000_0010, "reset pin keeps flag");
    chk(reset_vector_o, 32'h0000_0000, "vector");
    repeat (4) @(posedge core_clk_i);
    chk(core_reset_o, 32'h0000_0000, "core reset released");
    @(posedge core_clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    rd(PC, 32'h0000_0010, "reset keeps flag");
    bus(1'b1, PC, 8'hCC, 4'hF);
    rd(PC, 32'h0000_00CC, "flag cleared, bits stored");
    for (int m = 0; m < 4; m++)
    begin
      serial_mode_i <= m[1:0];
      cpu_ale_i <= m[0];
      prog_strobe_in <= m[1];
      repeat (3) @(posedge core_clk_i);
      chk(baud_double_o, {31'h0, m != 0}, "baud doubling");
      chk(frame_error_select_o, 32'h0000_0001, "frame error select");
      chk({ale_o, program_store_strobe_o}, {30'h0, m[0], m[1]}, "strobes follow");
    end
    // Odd sources enter with one request bit, even ones with both
    for (int k = 0; k < 8; k++)
    begin
      bus(1'b1, PC, (k % 2) ? 8'hCE : 8'hCF, 4'hF);
      repeat (2) @(posedge core_clk_i);
      chk({osc_run_o, flash_en_o, periph_clk_en_o, port_hold_o}, 32'h0000_0001,
        "power-down outputs");
      P.wake(k, n);
      chk(n > SETTLE, 32'h0000_0001, "settle length");
      rd(PC, 32'h0000_00CC, "wake clears requests");
      repeat (500) @(posedge core_clk_i);
    end
    rd(12'h000, 32'h0000_0000, "unmapped read");
    bus(1'b1, PC, 8'h00, 4'h0);
    rd(PC, 32'h0000_00CC, "write without lane ignored");
    // Reset pin as the wake source from power-down
    bus(1'b1, PC, 8'hCE, 4'hF);
    P.hold_reset(40);
    chk(core_reset_o, 32'h0000_0001, "reset pin wakes power-down");
    repeat (8) @(posedge core_clk_i);
    chk({cpu_clk_en_o, osc_run_o, flash_en_o}, 32'h0000_0007, "run after reset wake");
    rd(PC, 32'h0000_0000, "reset wake clears bits");
    final_report();
  end
endmodule : power_mode_controller_tb
